// [bench/pmr_register_bank_asserts.sv]
// Assertions on the management register bank ports
`timescale 1ns/1ps
module pmr_register_bank_asserts (
  // Clock, reset and access
  input wire logic        i_mclk,
  input wire logic        i_resetn,
  input wire logic        i_mgmt_valid,
  input wire logic        i_mgmt_write,
  input wire logic [4:0]  i_mgmt_addr,
  input wire logic [15:0] i_mgmt_wdata,
  input wire logic        o_mgmt_ack,
  input wire logic [15:0] o_mgmt_rdata,
  // Controls and MII
  input wire logic        o_an_restart,
  input wire logic        o_isolate,
  input wire logic        o_loopback,
  input wire logic        o_full_duplex,
  input wire logic [15:0] o_adv_word,
  input wire logic [3:0]  i_mac_txd,
  input wire logic [3:0]  o_mac_rxd,
  input wire logic        o_mac_rx_dv,
  input wire logic        o_line_tx_en,
  input wire logic [3:0]  o_line_txd,
  input wire logic [3:0]  i_line_rxd
);
  logic rst_req_q;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);
  // Restart request seen in a control write, soft reset excluded
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_req_q <= 1'h0;
    end else begin
      rst_req_q <= i_mgmt_valid && i_mgmt_write && i_mgmt_addr == pmr_pkg::ADDR_CONTROL
                   && i_mgmt_wdata[pmr_pkg::CTL_AN_RESTART] && !i_mgmt_wdata[pmr_pkg::CTL_SOFT_RESET];
    end
  end
  property p_ack_one;
    i_mgmt_valid |=> o_mgmt_ack;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack missing after access");
  property p_ack_none;
    !i_mgmt_valid |=> !o_mgmt_ack;
  endproperty
  a_ack_none: assert property (p_ack_none) else $error("ack without access");
  property p_restart;
    o_an_restart == rst_req_q;
  endproperty
  a_restart: assert property (p_restart) else $error("restart pulse mismatch");
  property p_isolate;
    o_isolate |=> o_mac_rxd == 4'h0 && !o_mac_rx_dv && !o_line_tx_en;
  endproperty
  a_isolate: assert property (p_isolate) else $error("MII active while isolated");
  property p_loop;
    o_loopback && !o_isolate |=> o_mac_rxd == $past(i_mac_txd) && !o_line_tx_en;
  endproperty
  a_loop: assert property (p_loop) else $error("loopback path wrong");
  property p_pass;
    !o_isolate && !o_loopback |=> o_line_txd == $past(i_mac_txd) && o_mac_rxd == $past(i_line_rxd);
  endproperty
  a_pass: assert property (p_pass) else $error("MII pass path wrong");
  property p_duplex;
    o_loopback |-> o_full_duplex;
  endproperty
  a_duplex: assert property (p_duplex) else $error("duplex bit used in loopback");
  property p_adv;
    o_adv_word[15:14] == 2'h0 && o_adv_word[4:0] == pmr_pkg::ADV_SELECTOR;
  endproperty
  a_adv: assert property (p_adv) else $error("advert fixed fields wrong");
  property p_status;
    i_mgmt_valid && !i_mgmt_write && i_mgmt_addr == pmr_pkg::ADDR_STATUS |=>
      o_mgmt_rdata[15] == 1'h0 && o_mgmt_rdata[12:11] == 2'h3 && o_mgmt_rdata[10:6] == 5'h00
      && o_mgmt_rdata[3] == 1'h1 && o_mgmt_rdata[0] == 1'h1;
  endproperty
  a_status: assert property (p_status) else $error("status fixed bits wrong");
  property p_ident;
    i_mgmt_valid && !i_mgmt_write && i_mgmt_addr == pmr_pkg::ADDR_IDENT_HI |=>
      o_mgmt_rdata == pmr_pkg::IDENT_HI_VALUE;
  endproperty
  a_ident: assert property (p_ident) else $error("identifier word wrong");
endmodule : pmr_register_bank_asserts

// [bench/pmr_station.sv]
// Management station model issuing register accesses
`timescale 1ns/1ps
module pmr_station (
  // Clock
  input  wire logic        i_mclk,
  // Access request
  output logic             o_mgmt_valid,
  output logic             o_mgmt_write,
  output logic      [4:0]  o_mgmt_addr,
  output logic      [15:0] o_mgmt_wdata,
  // Answer
  input  wire logic        i_mgmt_ack,
  input  wire logic [15:0] i_mgmt_rdata
);
  initial begin
    o_mgmt_valid = 1'h0;
    o_mgmt_write = 1'h0;
    o_mgmt_addr  = 5'h00;
    o_mgmt_wdata = 16'h0000;
  end
  task automatic access(input logic wr, input logic [4:0] a, input logic [15:0] d, output logic [15:0] q);
    int n;
    @(negedge i_mclk);
    o_mgmt_valid = 1'h1;
    o_mgmt_write = wr;
    o_mgmt_addr  = a;
    o_mgmt_wdata = (wr && a == pmr_pkg::ADDR_CONTROL) ? {d[15:7], 7'h00} : d;
    @(negedge i_mclk);
    o_mgmt_valid = 1'h0;
    o_mgmt_addr  = ~a;
    o_mgmt_wdata = ~o_mgmt_wdata;
    for (n = 0; n < 4 && i_mgmt_ack !== 1'h1; n++) @(negedge i_mclk);
    q = (i_mgmt_ack === 1'h1) ? i_mgmt_rdata : 16'hxxxx;
  endtask : access
endmodule : pmr_station

// [bench/tb_phy_mgmt_register_bank.sv]
// Self-checking bench of the management register bank
`timescale 1ns/1ps
module tb_phy_mgmt_register_bank;
  typedef struct packed {logic w; logic [4:0] a; logic [15:0] d; logic [15:0] e;} pmr_row_type;
  logic        clk = 1'h0, rst_n = 1'h0, strap = 1'h0, link = 1'h1, jab = 1'h0;
  logic        rfault = 1'h0, ancmp = 1'h0, txen = 1'h0, lrxdv = 1'h0, an100 = 1'h1, anfdx = 1'h1;
  logic        valid, wr, ack, an_en, restart, pdown, iso, loop, sp100, fdx, rxdv, ltxen;
  logic [4:0]  addr;
  logic [15:0] wdata, rdata, adv, q;
  logic [3:0]  txd = 4'h0, lrxd = 4'h0, rxd, ltxd;
  int          num_errors = 0;
  int          num_checks = 0;
  pmr_row_type rows [0:24] = '{
    '{1'h0, 5'h00, 16'h0000, 16'h3180}, '{1'h0, 5'h01, 16'h0000, 16'h7809},
    '{1'h0, 5'h01, 16'h0000, 16'h780D}, '{1'h0, 5'h02, 16'h0000, pmr_pkg::IDENT_HI_VALUE},
    '{1'h0, 5'h03, 16'h0000, pmr_pkg::IDENT_LO_VALUE}, '{1'h0, 5'h04, 16'h0000, 16'h05E1},
    '{1'h1, 5'h04, 16'hFFFF, 16'h0000}, '{1'h0, 5'h04, 16'h0000, 16'h3FE1},
    '{1'h1, 5'h01, 16'hFFFF, 16'h0000}, '{1'h0, 5'h01, 16'h0000, 16'h780D},
    '{1'h1, 5'h1F, 16'hFFFF, 16'h0000}, '{1'h0, 5'h1F, 16'h0000, 16'h0000},
    '{1'h1, 5'h00, 16'h0980, 16'h0000}, '{1'h0, 5'h00, 16'h0000, 16'h0880},
    '{1'h1, 5'h00, 16'h0100, 16'h0000}, '{1'h0, 5'h00, 16'h0000, 16'h0100},
    '{1'h1, 5'h00, 16'h8000, 16'h0000}, '{1'h0, 5'h00, 16'h0000, 16'h3180},
    '{1'h0, 5'h04, 16'h0000, 16'h05E1}, '{1'h1, 5'h00, 16'h3680, 16'h0000},
    '{1'h0, 5'h00, 16'h0000, 16'h3580}, '{1'h1, 5'h00, 16'h7080, 16'h0000},
    '{1'h0, 5'h00, 16'h0000, 16'h7180}, '{1'h1, 5'h00, 16'h4080, 16'h0000},
    '{1'h0, 5'h00, 16'h0000, 16'h4080}};

  always #4 clk = ~clk;
  // MII traffic in both directions
  always @(negedge clk) begin
    txd <= txd + 4'h1;
    txen <= ~txen;
    lrxd <= lrxd - 4'h1;
    lrxdv <= txen;
  end

  pmr_register_bank dut_u (
    .i_mclk(clk), .i_resetn(rst_n), .i_mgmt_valid(valid), .i_mgmt_write(wr), .i_mgmt_addr(addr),
    .i_mgmt_wdata(wdata), .o_mgmt_ack(ack), .o_mgmt_rdata(rdata), .i_fast_speed_advert_disable_strap(strap),
    .i_link_ok(link), .i_jabber(jab), .i_remote_fault(rfault), .i_an_complete(ancmp),
    .i_an_speed_100(an100), .i_an_full_duplex(anfdx), .o_an_enable(an_en), .o_an_restart(restart),
    .o_power_down(pdown), .o_isolate(iso), .o_loopback(loop), .o_speed_100(sp100), .o_full_duplex(fdx),
    .o_adv_word(adv), .i_mac_txd(txd), .i_mac_tx_en(txen), .o_mac_rxd(rxd), .o_mac_rx_dv(rxdv),
    .o_line_txd(ltxd), .o_line_tx_en(ltxen), .i_line_rxd(lrxd), .i_line_rx_dv(lrxdv));
  pmr_station st_u (
    .i_mclk(clk), .o_mgmt_valid(valid), .o_mgmt_write(wr), .o_mgmt_addr(addr), .o_mgmt_wdata(wdata),
    .i_mgmt_ack(ack), .i_mgmt_rdata(rdata));

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic stop_test();
    $display("Checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test

  initial begin
    #20000;
    num_errors++;
    stop_test();
  end

  initial begin
    repeat (15) @(negedge clk);
    check("reset_adv", adv, 16'h05E1);
    check("reset_ctl", {11'h000, an_en, sp100, pdown, iso, loop}, 16'h0018);
    @(negedge clk);
    rst_n = 1'h1;
    foreach (rows[i]) begin
      st_u.access(rows[i].w, rows[i].a, rows[i].d, q);
      if (!rows[i].w) check("row", q, rows[i].e);
    end
    check("full_duplex", {15'h0000, fdx}, 16'h0001);
    st_u.access(1'h1, pmr_pkg::ADDR_CONTROL, 16'h1280, q);
    check("restart", {15'h0000, restart}, 16'h0001);
    check("an_result", {14'h0000, sp100, fdx}, 16'h0003);
    st_u.access(1'h1, pmr_pkg::ADDR_CONTROL, 16'h0000, q);
    check("manual_mode", {14'h0000, sp100, fdx}, 16'h0000);
    @(negedge clk);
    strap = 1'h1;
    rfault = 1'h1;
    ancmp = 1'h1;
    jab = 1'h1;
    link = 1'h0;
    @(negedge clk);
    jab = 1'h0;
    link = 1'h1;
    repeat (3) @(negedge clk);
    st_u.access(1'h0, pmr_pkg::ADDR_STATUS, 16'h0000, q);
    check("status_events", q, 16'h183B);
    st_u.access(1'h0, pmr_pkg::ADDR_STATUS, 16'h0000, q);
    check("status_cleared", q, 16'h183D);
    st_u.access(1'h1, pmr_pkg::ADDR_ADVERT, 16'h0000, q);
    check("adv_cleared", adv, 16'h0001);
    rst_n = 1'h0;
    @(negedge clk);
    check("rerst_adv", adv, 16'h05E1);
    rst_n = 1'h1;
    st_u.access(1'h0, pmr_pkg::ADDR_CONTROL, 16'h0000, q);
    check("rerst_ctl", q, 16'h3180);
    stop_test();
  end
endmodule : tb_phy_mgmt_register_bank

bind pmr_register_bank pmr_register_bank_asserts chk_u (
  .i_mclk(i_mclk), .i_resetn(i_resetn), .i_mgmt_valid(i_mgmt_valid), .i_mgmt_write(i_mgmt_write),
  .i_mgmt_addr(i_mgmt_addr), .i_mgmt_wdata(i_mgmt_wdata), .o_mgmt_ack(o_mgmt_ack),
  .o_mgmt_rdata(o_mgmt_rdata), .o_an_restart(o_an_restart), .o_isolate(o_isolate), .o_loopback(o_loopback),
  .o_full_duplex(o_full_duplex), .o_adv_word(o_adv_word), .i_mac_txd(i_mac_txd), .o_mac_rxd(o_mac_rxd),
  .o_mac_rx_dv(o_mac_rx_dv), .o_line_tx_en(o_line_tx_en), .o_line_txd(o_line_txd), .i_line_rxd(i_line_rxd));

// [core/pmr_register_bank.sv]
// Management register bank with control, status, identifier and advertisement words
// Operation
// - Control bit 10 isolates internal MII from controller, both directions; resets zero.
// - Writing one to control bit 9 restarts auto-negotiation unless the same write sets soft reset bit 15; bit self-clears, reads zero.
// - Duplex bit 8 writable when auto-negotiation off; reads one when on.
// - In loopback, device behaviour ignores the duplex control bit.
// - Control bit 7 has no function, writable, resets to one.
// - Reserved control 6:0 and status 15, 10:7 read zero.
// - Status 14 and 13 report 100 Mbps ability, zero when strap active.
// - Status 12 and 11 report 10 Mbps full and half duplex, read one.
// - Status bit 6 reads zero; station always sends full preamble.
// - Status bit 5 shows auto-negotiation completion, taken straight from i_an_complete.
// - Status bit 4 shows detected remote fault.
// - Status bit 3 reads one: auto-negotiation ability.
// - Status bit 2 is latch-low link status, resets zero.
// - Status bit 1 is latch-high jabber flag, meaningful at 10 Mbps only.
// - Status bit 0 reads one: extended registers present.
// - Registers 2 and 3 return fixed upper and lower identifier halves.
// - Advertisement bit 15 is constant zero.
// - Advertisement bit 13 writable remote fault, resets zero.
// - Advertisement bits 12:5 writable technology field, reset 00101111.
// - Advertisement bits 4:0 fixed selector 00001.
// - Latched status bits hold their event value until read or soft reset.
// - Control bit 12 enables auto-negotiation, overriding manual speed and duplex.
// - Control bit 14 loops transmit nibbles to receive when bit 10 is clear, network isolated.
// - Registers are reached only through management frame accesses.
`timescale 1ns/1ps
module pmr_register_bank (
  // Clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_resetn,
  // Decoded management frame access
  input  wire logic        i_mgmt_valid,
  input  wire logic        i_mgmt_write,
  input  wire logic [4:0]  i_mgmt_addr,
  input  wire logic [15:0] i_mgmt_wdata,
  output logic             o_mgmt_ack,
  output logic      [15:0] o_mgmt_rdata,
  // Strap pin
  input  wire logic        i_fast_speed_advert_disable_strap,
  // Line status from the physical layer
  input  wire logic        i_link_ok,
  input  wire logic        i_jabber,
  input  wire logic        i_remote_fault,
  input  wire logic        i_an_complete,
  input  wire logic        i_an_speed_100,
  input  wire logic        i_an_full_duplex,
  // Controls to the physical layer
  output logic             o_an_enable,
  output logic             o_an_restart,
  output logic             o_power_down,
  output logic             o_isolate,
  output logic             o_loopback,
  output logic             o_speed_100,
  output logic             o_full_duplex,
  output logic      [15:0] o_adv_word,
  // Controller side MII
  input  wire logic [3:0]  i_mac_txd,
  input  wire logic        i_mac_tx_en,
  output logic      [3:0]  o_mac_rxd,
  output logic             o_mac_rx_dv,
  // Line side MII
  output logic      [3:0]  o_line_txd,
  output logic             o_line_tx_en,
  input  wire logic [3:0]  i_line_rxd,
  input  wire logic        i_line_rx_dv
);

  logic        strap_meta_q;
  logic        strap_q;
  logic        loopback_q;
  logic        speed_q;
  logic        an_enable_q;
  logic        power_down_q;
  logic        isolate_q;
  logic        duplex_q;
  logic        col_test_q;
  logic        restart_q;
  logic        adv_rfault_q;
  logic [7:0]  adv_tech_q;
  logic        link_lat_q;
  logic        jabber_lat_q;
  logic        ctl_wr;
  logic        adv_wr;
  logic        sts_rd;
  logic        soft_rst;
  logic        speed_eff;
  logic        duplex_eff;
  logic [15:0] ctl_word;
  logic [15:0] sts_word;
  logic [15:0] adv_word;
  logic [15:0] rdata_d;

  // Accesses come only from decoded frames
  assign ctl_wr   = i_mgmt_valid && i_mgmt_write && (i_mgmt_addr == pmr_pkg::ADDR_CONTROL);
  assign adv_wr   = i_mgmt_valid && i_mgmt_write && (i_mgmt_addr == pmr_pkg::ADDR_ADVERT);
  assign sts_rd   = i_mgmt_valid && !i_mgmt_write && (i_mgmt_addr == pmr_pkg::ADDR_STATUS);
  assign soft_rst = ctl_wr && i_mgmt_wdata[pmr_pkg::CTL_SOFT_RESET];

  // Strap synchroniser
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      strap_meta_q <= 1'b0;
      strap_q      <= 1'b0;
    end else begin
      strap_meta_q <= i_fast_speed_advert_disable_strap;
      strap_q      <= strap_meta_q;
    end
  end

  // Control register
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      loopback_q   <= pmr_pkg::RST_LOOPBACK;
      speed_q      <= pmr_pkg::RST_SPEED;
      an_enable_q  <= pmr_pkg::RST_AN_ENABLE;
      power_down_q <= pmr_pkg::RST_POWER_DOWN;
      isolate_q    <= pmr_pkg::RST_ISOLATE;
      duplex_q     <= pmr_pkg::RST_DUPLEX;
      col_test_q   <= pmr_pkg::RST_COL_TEST;
    end else if (soft_rst) begin
      loopback_q   <= pmr_pkg::RST_LOOPBACK;
      speed_q      <= pmr_pkg::RST_SPEED;
      an_enable_q  <= pmr_pkg::RST_AN_ENABLE;
      power_down_q <= pmr_pkg::RST_POWER_DOWN;
      isolate_q    <= pmr_pkg::RST_ISOLATE;
      duplex_q     <= pmr_pkg::RST_DUPLEX;
      col_test_q   <= pmr_pkg::RST_COL_TEST;
    end else if (ctl_wr) begin
      loopback_q   <= i_mgmt_wdata[pmr_pkg::CTL_LOOPBACK];
      speed_q      <= i_mgmt_wdata[pmr_pkg::CTL_SPEED];
      an_enable_q  <= i_mgmt_wdata[pmr_pkg::CTL_AN_ENABLE];
      power_down_q <= i_mgmt_wdata[pmr_pkg::CTL_POWER_DOWN];
      isolate_q    <= i_mgmt_wdata[pmr_pkg::CTL_ISOLATE];
      col_test_q   <= i_mgmt_wdata[pmr_pkg::CTL_COL_TEST];
      // Duplex writable only when negotiation off
      if (!an_enable_q) begin
        duplex_q <= i_mgmt_wdata[pmr_pkg::CTL_DUPLEX];
      end
    end
  end

  // Restart is a one-cycle pulse, never stored
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      restart_q <= 1'b0;
    end else begin
      restart_q <= ctl_wr && !soft_rst && i_mgmt_wdata[pmr_pkg::CTL_AN_RESTART];
    end
  end

  // Advertisement register
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      adv_rfault_q <= pmr_pkg::RST_ADV_RFAULT;
      adv_tech_q   <= pmr_pkg::RST_ADV_TECH;
    end else if (soft_rst) begin
      adv_rfault_q <= pmr_pkg::RST_ADV_RFAULT;
      adv_tech_q   <= pmr_pkg::RST_ADV_TECH;
    end else if (adv_wr) begin
      adv_rfault_q <= i_mgmt_wdata[pmr_pkg::ADV_RFAULT];
      adv_tech_q   <= i_mgmt_wdata[pmr_pkg::ADV_TECH_HI:pmr_pkg::ADV_TECH_LO];
    end
  end

  // Link latch-low, reloads on status read
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      link_lat_q <= 1'b0;
    end else if (!i_link_ok) begin
      // Low event wins over the read
      link_lat_q <= 1'b0;
    end else if (sts_rd || soft_rst) begin
      link_lat_q <= 1'b1;
    end
  end

  // Jabber latch-high, only at 10 Mbps
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      jabber_lat_q <= 1'b0;
    end else if (i_jabber && !speed_eff) begin
      // High event wins over the read
      jabber_lat_q <= 1'b1;
    end else if (sts_rd || soft_rst) begin
      jabber_lat_q <= 1'b0;
    end
  end

  assign speed_eff  = an_enable_q ? i_an_speed_100 : speed_q;
  // Loopback runs full duplex regardless of the duplex bit
  assign duplex_eff = loopback_q ? 1'b1 : (an_enable_q ? i_an_full_duplex : duplex_q);

  // Control read word
  always_comb begin
    // Reserved and self-clearing bits read zero
    ctl_word = 16'h0000;
    ctl_word[pmr_pkg::CTL_LOOPBACK]   = loopback_q;
    ctl_word[pmr_pkg::CTL_SPEED]      = speed_q;
    ctl_word[pmr_pkg::CTL_AN_ENABLE]  = an_enable_q;
    ctl_word[pmr_pkg::CTL_POWER_DOWN] = power_down_q;
    ctl_word[pmr_pkg::CTL_ISOLATE]    = isolate_q;
    ctl_word[pmr_pkg::CTL_DUPLEX]     = an_enable_q ? 1'b1 : duplex_q;
    ctl_word[pmr_pkg::CTL_COL_TEST]   = col_test_q;
  end

  // Status read word
  // No write path to read-only bits
  always_comb begin
    sts_word = 16'h0000;
    // 100 Mbps ability follows the strap
    sts_word[pmr_pkg::STS_TX_FD]    = !strap_q;
    sts_word[pmr_pkg::STS_TX_HD]    = !strap_q;
    sts_word[pmr_pkg::STS_T_FD]     = 1'b1;
    sts_word[pmr_pkg::STS_T_HD]     = 1'b1;
    sts_word[pmr_pkg::STS_PREAMBLE] = 1'b0;
    sts_word[pmr_pkg::STS_AN_DONE]  = i_an_complete;
    sts_word[pmr_pkg::STS_RFAULT]   = i_remote_fault;
    sts_word[pmr_pkg::STS_AN_ABLE]  = 1'b1;
    sts_word[pmr_pkg::STS_LINK]     = link_lat_q;
    sts_word[pmr_pkg::STS_JABBER]   = jabber_lat_q;
    sts_word[pmr_pkg::STS_EXT_CAP]  = 1'b1;
  end

  // Advertisement read word
  always_comb begin
    adv_word = 16'h0000;
    adv_word[pmr_pkg::ADV_NEXT_PAGE] = 1'b0;
    adv_word[pmr_pkg::ADV_RFAULT]    = adv_rfault_q;
    adv_word[pmr_pkg::ADV_TECH_HI:pmr_pkg::ADV_TECH_LO] = adv_tech_q;
    adv_word[4:0] = pmr_pkg::ADV_SELECTOR;
  end

  // Read multiplexer, unmapped addresses read zero
  always_comb begin
    unique case (i_mgmt_addr)
      pmr_pkg::ADDR_CONTROL: begin
        rdata_d = ctl_word;
      end
      pmr_pkg::ADDR_STATUS: begin
        rdata_d = sts_word;
      end
      pmr_pkg::ADDR_IDENT_HI: begin
        rdata_d = pmr_pkg::IDENT_HI_VALUE;
      end
      pmr_pkg::ADDR_IDENT_LO: begin
        rdata_d = pmr_pkg::IDENT_LO_VALUE;
      end
      pmr_pkg::ADDR_ADVERT: begin
        rdata_d = adv_word;
      end
      default: begin
        rdata_d = 16'h0000;
      end
    endcase
  end

  // Access answer, one cycle after the request
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_mgmt_ack <= 1'b0;
    end else begin
      o_mgmt_ack <= i_mgmt_valid;
    end
  end

  // Read data, held until the next read
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_mgmt_rdata <= 16'h0000;
    end else if (i_mgmt_valid && !i_mgmt_write) begin
      o_mgmt_rdata <= rdata_d;
    end
  end

  // MII receive path to the controller
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_mac_rxd   <= 4'h0;
      o_mac_rx_dv <= 1'b0;
    end else if (isolate_q) begin
      o_mac_rxd   <= 4'h0;
      o_mac_rx_dv <= 1'b0;
    end else if (loopback_q) begin
      o_mac_rxd   <= i_mac_txd;
      o_mac_rx_dv <= i_mac_tx_en;
    end else begin
      o_mac_rxd   <= i_line_rxd;
      o_mac_rx_dv <= i_line_rx_dv;
    end
  end

  // MII transmit path to the line
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_line_txd   <= 4'h0;
      o_line_tx_en <= 1'b0;
    end else if (isolate_q) begin
      o_line_txd   <= 4'h0;
      o_line_tx_en <= 1'b0;
    end else if (loopback_q) begin
      o_line_txd   <= 4'h0;
      o_line_tx_en <= 1'b0;
    end else begin
      o_line_txd   <= i_mac_txd;
      o_line_tx_en <= i_mac_tx_en;
    end
  end

  // Controls to the physical layer
  assign o_an_enable   = an_enable_q;
  assign o_an_restart  = restart_q;
  assign o_power_down  = power_down_q;
  assign o_isolate     = isolate_q;
  assign o_loopback    = loopback_q;
  assign o_speed_100   = speed_eff;
  assign o_full_duplex = duplex_eff;
  assign o_adv_word    = adv_word;

endmodule : pmr_register_bank

// [pkg/pmr_pkg.sv]
// Constants of the management register bank
package pmr_pkg;
  // Register addresses
  localparam logic [4:0]  ADDR_CONTROL   = 5'h00;
  localparam logic [4:0]  ADDR_STATUS    = 5'h01;
  localparam logic [4:0]  ADDR_IDENT_HI  = 5'h02;
  localparam logic [4:0]  ADDR_IDENT_LO  = 5'h03;
  localparam logic [4:0]  ADDR_ADVERT    = 5'h04;
  // Control bit positions
  localparam int          CTL_SOFT_RESET = 15;
  localparam int          CTL_LOOPBACK   = 14;
  localparam int          CTL_SPEED      = 13;
  localparam int          CTL_AN_ENABLE  = 12;
  localparam int          CTL_POWER_DOWN = 11;
  localparam int          CTL_ISOLATE    = 10;
  localparam int          CTL_AN_RESTART = 9;
  localparam int          CTL_DUPLEX     = 8;
  localparam int          CTL_COL_TEST   = 7;
  // Control reset values
  localparam logic        RST_LOOPBACK   = 1'b0;
  localparam logic        RST_SPEED      = 1'b1;
  localparam logic        RST_AN_ENABLE  = 1'b1;
  localparam logic        RST_POWER_DOWN = 1'b0;
  localparam logic        RST_ISOLATE    = 1'b0;
  localparam logic        RST_DUPLEX     = 1'b0;
  localparam logic        RST_COL_TEST   = 1'b1;
  // Status bit positions
  localparam int          STS_TX_FD      = 14;
  localparam int          STS_TX_HD      = 13;
  localparam int          STS_T_FD       = 12;
  localparam int          STS_T_HD       = 11;
  localparam int          STS_PREAMBLE   = 6;
  localparam int          STS_AN_DONE    = 5;
  localparam int          STS_RFAULT     = 4;
  localparam int          STS_AN_ABLE    = 3;
  localparam int          STS_LINK       = 2;
  localparam int          STS_JABBER     = 1;
  localparam int          STS_EXT_CAP    = 0;
  // Advertisement fields
  localparam int          ADV_NEXT_PAGE  = 15;
  localparam int          ADV_RFAULT     = 13;
  localparam int          ADV_TECH_HI    = 12;
  localparam int          ADV_TECH_LO    = 5;
  localparam logic        RST_ADV_RFAULT = 1'b0;
  localparam logic [7:0]  RST_ADV_TECH   = 8'h2F;
  localparam logic [4:0]  ADV_SELECTOR   = 5'h01;
  // Identifier words, values arbitrary
  localparam logic [15:0] IDENT_HI_VALUE = 16'h1234;
  localparam logic [15:0] IDENT_LO_VALUE = 16'h5670;
endpackage : pmr_pkg
